// [rtl/lmsb_bank.sv]
// twelve 8-bit settings registers with decoded configuration outputs
// assumes the serial interface decoder presents one-cycle rd/wr strobes on clk
//
// Operation
// R01 - slots 13 to 15 hold 7-bit channel numbers, resets 0x2C, 0x2F, 0x32
// R02 - bit 5 of poll/crc/role register selects reversed CRC bit order
// R03 - bit 0 of poll/crc/role register: 0 client, 1 master; reset 0x1E
// R04 - bit 7 of xtal/sync register: 0 under 1 ms, 1 under 2 ms; reset 0x8F
// R05 - polling field bits 7:6 decode to 0.25, 0.50, 1.00, 2.00 s
`timescale 1ns/10ps
`include "lmsb_map.svh"
module lmsb_bank (
  input wire logic clk,
  input wire logic reset,
  input lmsb_pkg::lmsb_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  output lmsb_pkg::lmsb_cfg_t cfg
);
  // entry index of each register, lowest offset first
  localparam int IDX_SLOT_13 = 0;
  localparam int IDX_SLOT_14 = 1;
  localparam int IDX_SLOT_15 = 2;
  localparam int IDX_CAL = 3;
  localparam int IDX_COMM = 4;
  localparam int IDX_SCALE_PWR = 5;
  localparam int IDX_TIME_CODE = 6;
  localparam int IDX_NOWUP_HIGH = 7;
  localparam int IDX_NOWUP_LOW = 8;
  localparam int IDX_TRIAL = 9;
  localparam int IDX_POLL_CRC_ROLE = 10;
  localparam int IDX_XTAL_SYNC = 11;

  // offset of each entry; the list runs from the highest entry down
  localparam logic [`LMSB_NUM_REGS-1:0][7:0] OFS = {
    `LMSB_OFS_XTAL_SYNC,
    `LMSB_OFS_POLL_CRC_ROLE,
    `LMSB_OFS_PAIR_TRIAL,
    `LMSB_OFS_NOWUP_LOW,
    `LMSB_OFS_NOWUP_HIGH,
    `LMSB_OFS_PAIR_TIME_CODE,
    `LMSB_OFS_PAIR_SCALE_PWR,
    `LMSB_OFS_PAIR_COMM,
    `LMSB_OFS_PAIR_CAL,
    `LMSB_OFS_ACS_SLOT_15,
    `LMSB_OFS_ACS_SLOT_14,
    `LMSB_OFS_ACS_SLOT_13
  };

  // value of each entry after reset
  localparam logic [`LMSB_NUM_REGS-1:0][7:0] RST_VAL = {
    `LMSB_RST_XTAL_SYNC,
    `LMSB_RST_POLL_CRC_ROLE,
    `LMSB_RST_PAIR_TRIAL,
    `LMSB_RST_NOWUP_LOW,
    `LMSB_RST_NOWUP_HIGH,
    `LMSB_RST_PAIR_TIME_CODE,
    `LMSB_RST_PAIR_SCALE_PWR,
    `LMSB_RST_PAIR_COMM,
    `LMSB_RST_PAIR_CAL,
    `LMSB_RST_ACS_SLOT_15,
    `LMSB_RST_ACS_SLOT_14,
    `LMSB_RST_ACS_SLOT_13
  };

  // unused bits, except bit 6 of the xtal/sync register, are never stored, so they read back as zero
  localparam logic [`LMSB_NUM_REGS-1:0][7:0] WMASK = {
    `LMSB_MASK_8BIT,
    `LMSB_MASK_8BIT,
    `LMSB_MASK_8BIT,
    `LMSB_MASK_8BIT,
    `LMSB_MASK_7BIT,
    `LMSB_MASK_8BIT,
    `LMSB_MASK_6BIT,
    `LMSB_MASK_3BIT,
    `LMSB_MASK_7BIT,
    `LMSB_MASK_7BIT,
    `LMSB_MASK_7BIT,
    `LMSB_MASK_7BIT
  };

  // one decoder for the reset image and every update, so the two never drift apart
  function automatic lmsb_pkg::lmsb_cfg_t decode_cfg(
    input logic [`LMSB_NUM_REGS-1:0][7:0] regs
  );
    lmsb_pkg::lmsb_cfg_t c;
    logic [7:0] pcr;
    logic [7:0] xts;
    c = '0;
    pcr = regs[IDX_POLL_CRC_ROLE];
    xts = regs[IDX_XTAL_SYNC];

    // channel slots 13 to 15
    c.channel_13 = regs[IDX_SLOT_13][6:0]; // R01
    c.channel_14 = regs[IDX_SLOT_14][6:0]; // R01
    c.channel_15 = regs[IDX_SLOT_15][6:0]; // R01

    // pairing and wake-up table
    c.calibration_value = regs[IDX_CAL][6:0];
    c.comm_slot = regs[IDX_COMM][2:0];
    c.time_code_scaling = regs[IDX_SCALE_PWR][5:4];
    c.output_power_level = regs[IDX_SCALE_PWR][3:0];
    c.time_code = regs[IDX_TIME_CODE];

    // 15-bit timeout split over two bytes; a half-written value is seen until the other byte is written
    c.no_wakeup_timeout = {regs[IDX_NOWUP_HIGH][6:0], regs[IDX_NOWUP_LOW]};
    c.trial_max = regs[IDX_TRIAL];

    // polling interval in milliseconds, so the consumer needs no table of its own
    case (pcr[7:6]) // R05
      2'b00:
      begin
        c.poll_max_ms = `LMSB_POLL_MS_0;
      end
      2'b01:
      begin
        c.poll_max_ms = `LMSB_POLL_MS_1;
      end
      2'b10:
      begin
        c.poll_max_ms = `LMSB_POLL_MS_2;
      end
      2'b11:
      begin
        c.poll_max_ms = `LMSB_POLL_MS_3;
      end
      default:
      begin
        c.poll_max_ms = `LMSB_POLL_MS_0;
      end
    endcase
    c.crc_reverse = pcr[`LMSB_BIT_CRC_REVERSE]; // R02
    c.rx_on_time = pcr[4:3];
    c.duty_cycle = pcr[2:1];
    c.role_master = pcr[`LMSB_BIT_ROLE_MASTER]; // R03

    // crystal allowance and sync loss limit; bit 6 is kept but drives nothing
    c.xtal_slow_start = xts[`LMSB_BIT_XTAL_SLOW]; // R04
    c.sync_lost_max = xts[5:0];
    return c;
  endfunction : decode_cfg

  // decoded reset image, so cfg agrees with the stored bytes from the first edge
  localparam lmsb_pkg::lmsb_cfg_t RST_CFG = decode_cfg(RST_VAL);

  lmsb_pkg::lmsb_state_t state_reg;
  lmsb_pkg::lmsb_state_t state_next;
  logic [`LMSB_NUM_REGS-1:0] entry_sel;
  logic [`LMSB_NUM_REGS-1:0][7:0] wr_val;

  // per entry: offset match and masked write value
  genvar g;
  generate
    for (g = 0; g < `LMSB_NUM_REGS; g++)
    begin : g_entry
      // full compare, so offsets just outside the bank never alias onto it
      assign entry_sel[g] = (req.addr == OFS[g]);
      assign wr_val[g] = req.wdata & WMASK[g];
    end
  endgenerate

  // reads answer from the old bytes: a write in the same cycle shows on the next read
  always_comb
  begin
    state_next = state_reg;
    state_next.rvalid = req.rd;
    // unmapped offsets and idle cycles answer zero
    state_next.rdata = 8'h00;
    if (req.rd)
    begin
      case (req.addr)
        `LMSB_OFS_ACS_SLOT_13:
        begin
          state_next.rdata = state_reg.regs[IDX_SLOT_13];
        end
        `LMSB_OFS_ACS_SLOT_14:
        begin
          state_next.rdata = state_reg.regs[IDX_SLOT_14];
        end
        `LMSB_OFS_ACS_SLOT_15:
        begin
          state_next.rdata = state_reg.regs[IDX_SLOT_15];
        end
        `LMSB_OFS_PAIR_CAL:
        begin
          state_next.rdata = state_reg.regs[IDX_CAL];
        end
        `LMSB_OFS_PAIR_COMM:
        begin
          state_next.rdata = state_reg.regs[IDX_COMM];
        end
        `LMSB_OFS_PAIR_SCALE_PWR:
        begin
          state_next.rdata = state_reg.regs[IDX_SCALE_PWR];
        end
        `LMSB_OFS_PAIR_TIME_CODE:
        begin
          state_next.rdata = state_reg.regs[IDX_TIME_CODE];
        end
        `LMSB_OFS_NOWUP_HIGH:
        begin
          state_next.rdata = state_reg.regs[IDX_NOWUP_HIGH];
        end
        `LMSB_OFS_NOWUP_LOW:
        begin
          state_next.rdata = state_reg.regs[IDX_NOWUP_LOW];
        end
        `LMSB_OFS_PAIR_TRIAL:
        begin
          state_next.rdata = state_reg.regs[IDX_TRIAL];
        end
        `LMSB_OFS_POLL_CRC_ROLE:
        begin
          state_next.rdata = state_reg.regs[IDX_POLL_CRC_ROLE];
        end
        `LMSB_OFS_XTAL_SYNC:
        begin
          state_next.rdata = state_reg.regs[IDX_XTAL_SYNC];
        end
        default:
        begin
          state_next.rdata = 8'h00;
        end
      endcase
    end
    for (int i = 0; i < `LMSB_NUM_REGS; i++)
    begin
      if (req.wr && entry_sel[i])
      begin
        state_next.regs[i] = wr_val[i]; // R01
      end
    end
    state_next.cfg = decode_cfg(state_next.regs); // R02 R03 R04 R05
  end

  // reset loads the bytes and their decoded image together
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg.regs <= RST_VAL; // R01 R03 R04
      state_reg.rdata <= 8'h00;
      state_reg.rvalid <= 1'b0;
      state_reg.cfg <= RST_CFG;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rdata = state_reg.rdata;
  assign rvalid = state_reg.rvalid;
  assign cfg = state_reg.cfg;
endmodule : lmsb_bank

// [shared/lmsb_map.svh]
// register offsets, reset values and field positions of the link manager settings bank
// assumes an 8-bit register address and 8-bit data from the serial configuration port
`ifndef LMSB_MAP_SVH
`define LMSB_MAP_SVH
`define LMSB_OFS_ACS_SLOT_13 8'h8d
`define LMSB_OFS_ACS_SLOT_14 8'h8e
`define LMSB_OFS_ACS_SLOT_15 8'h8f
`define LMSB_OFS_PAIR_CAL 8'h90
`define LMSB_OFS_PAIR_COMM 8'h91
`define LMSB_OFS_PAIR_SCALE_PWR 8'h92
`define LMSB_OFS_PAIR_TIME_CODE 8'h93
`define LMSB_OFS_NOWUP_HIGH 8'h94
`define LMSB_OFS_NOWUP_LOW 8'h95
`define LMSB_OFS_PAIR_TRIAL 8'h96
`define LMSB_OFS_POLL_CRC_ROLE 8'h97
`define LMSB_OFS_XTAL_SYNC 8'h98
`define LMSB_NUM_REGS 12
`define LMSB_RST_ACS_SLOT_13 8'h2c
`define LMSB_RST_ACS_SLOT_14 8'h2f
`define LMSB_RST_ACS_SLOT_15 8'h32
`define LMSB_RST_PAIR_CAL 8'h05
`define LMSB_RST_PAIR_COMM 8'h00
`define LMSB_RST_PAIR_SCALE_PWR 8'h10
`define LMSB_RST_PAIR_TIME_CODE 8'h00
`define LMSB_RST_NOWUP_HIGH 8'h00
`define LMSB_RST_NOWUP_LOW 8'h0a
`define LMSB_RST_PAIR_TRIAL 8'h0f
`define LMSB_RST_POLL_CRC_ROLE 8'h1e
`define LMSB_RST_XTAL_SYNC 8'h8f
`define LMSB_MASK_7BIT 8'h7f
`define LMSB_MASK_3BIT 8'h07
`define LMSB_MASK_6BIT 8'h3f
`define LMSB_MASK_8BIT 8'hff
`define LMSB_BIT_CRC_REVERSE 5
`define LMSB_BIT_ROLE_MASTER 0
`define LMSB_BIT_XTAL_SLOW 7
// polling interval in milliseconds per field code
`define LMSB_POLL_MS_0 16'd250
`define LMSB_POLL_MS_1 16'd500
`define LMSB_POLL_MS_2 16'd1000
`define LMSB_POLL_MS_3 16'd2000
`endif

// [shared/lmsb_pkg.sv]
// types for the link manager settings bank
// offsets and reset values live in lmsb_map.svh
`include "lmsb_map.svh"
package lmsb_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lmsb_req_t;

  typedef struct packed {
    logic [6:0] channel_13;
    logic [6:0] channel_14;
    logic [6:0] channel_15;
    logic [6:0] calibration_value;
    logic [2:0] comm_slot;
    logic [1:0] time_code_scaling;
    logic [3:0] output_power_level;
    logic [7:0] time_code;
    logic [14:0] no_wakeup_timeout;
    logic [7:0] trial_max;
    logic [15:0] poll_max_ms;
    logic crc_reverse;
    logic [1:0] rx_on_time;
    logic [1:0] duty_cycle;
    logic role_master;
    logic xtal_slow_start;
    logic [5:0] sync_lost_max;
  } lmsb_cfg_t;

  typedef struct packed {
    logic [`LMSB_NUM_REGS-1:0][7:0] regs;
    logic [7:0] rdata;
    logic rvalid;
    lmsb_cfg_t cfg;
  } lmsb_state_t;
endpackage : lmsb_pkg

// [bench/lmsb_bank_props.sv]
// properties of the settings bank outputs
// assumes only the ports of lmsb_bank are visible
`timescale 1ns/10ps
module lmsb_bank_props (
  input wire logic clk,
  input wire logic reset,
  input lmsb_pkg::lmsb_req_t req,
  input logic [7:0] rdata,
  input logic rvalid,
  input lmsb_pkg::lmsb_cfg_t cfg
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  slot_write_a: assert property (req.wr && req.addr == 8'h8f
    |=> cfg.channel_15 == $past(req.wdata[6:0])) else $error("slot 15 not written");
  crc_order_a: assert property (req.wr && req.addr == 8'h97
    |=> cfg.crc_reverse == $past(req.wdata[5])) else $error("crc order wrong");
  role_bit_a: assert property (req.wr && req.addr == 8'h97
    |=> cfg.role_master == $past(req.wdata[0])) else $error("role wrong");
  xtal_bit_a: assert property (req.wr && req.addr == 8'h98
    |=> cfg.xtal_slow_start == $past(req.wdata[7])) else $error("xtal wrong");
  poll_decode_a: assert property (req.wr && req.addr == 8'h97
    |=> cfg.poll_max_ms == (16'h00fa << $past(req.wdata[7:6]))) else $error("poll wrong");
endmodule : lmsb_bank_props
bind lmsb_bank lmsb_bank_props u_lmsb_bank_props (.clk(clk), .reset(reset), .req(req),
  .rdata(rdata), .rvalid(rvalid), .cfg(cfg));

// [bench/lmsb_host.sv]
// host model issuing one-cycle register strobes
// assumes rvalid answers exactly one cycle after the strobe
`timescale 1ns/10ps
module lmsb_host (
  input wire logic clk,
  output lmsb_pkg::lmsb_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial req = '0;
  task xfer(input logic wr, input logic [7:0] a, input logic [7:0] w, output logic [8:0] r);
    @(posedge clk);
    req <= '{wr: wr, rd: !wr, addr: a, wdata: w};
    @(posedge clk);
    // idle lines flip so a stale value never looks valid
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~w};
    #1 r = {rvalid, rdata};
  endtask : xfer
endmodule : lmsb_host

// [bench/lmsb_bank_tb.sv]
// self-checking bench for the settings bank
// assumes the host model makes every request
`timescale 1ns/10ps
module lmsb_bank_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  lmsb_pkg::lmsb_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  lmsb_pkg::lmsb_cfg_t cfg;
  int miscompares = 0;
  int comparisons = 0;
  localparam logic [7:0] rst_tbl [12] = '{8'h2c, 8'h2f, 8'h32, 8'h05, 8'h00, 8'h10,
    8'h00, 8'h00, 8'h0a, 8'h0f, 8'h1e, 8'h8f};
  localparam logic [7:0] keep_tbl [12] = '{8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h07, 8'h3f,
    8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};
  always #2 clk = ~clk;
  lmsb_bank u_lmsb_bank (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
    .rvalid(rvalid), .cfg(cfg));
  lmsb_host u_lmsb_host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  task summarize;
    if (miscompares == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task reset_values;
    logic [8:0] r;
    for (int i = 0; i < 12; i++)
    begin
      u_lmsb_host.xfer(1'b0, 8'h8d + 8'(i), 8'h00, r);
      chk(16'(r), {7'h00, 1'b1, rst_tbl[i]});
    end
    u_lmsb_host.xfer(1'b0, 8'h99, 8'h00, r);
    chk(16'(r), 16'h0100);
  endtask : reset_values
  task channel_slots;
    logic [8:0] r;
    u_lmsb_host.xfer(1'b1, 8'h8f, 8'hff, r);
    chk(16'(cfg.channel_15), 16'h007f);
    u_lmsb_host.xfer(1'b0, 8'h8f, 8'h00, r);
    chk(16'(r), 16'h017f);
  endtask : channel_slots
  task settings_fields;
    logic [8:0] r;
    for (int c = 0; c < 4; c++)
    begin
      u_lmsb_host.xfer(1'b1, 8'h97, {2'(c), c[0] ? 6'h21 : 6'h00}, r);
      chk(cfg.poll_max_ms, 16'h00fa << c);
      chk(16'(cfg.crc_reverse), 16'(c[0]));
      chk(16'(cfg.role_master), 16'(c[0]));
      u_lmsb_host.xfer(1'b1, 8'h98, {c[0], 7'h0f}, r);
      chk(16'(cfg.xtal_slow_start), 16'(c[0]));
    end
  endtask : settings_fields
  task unused_bits;
    logic [8:0] r;
    for (int i = 0; i < 12; i++)
    begin
      u_lmsb_host.xfer(1'b1, 8'h8d + 8'(i), 8'hff, r);
      u_lmsb_host.xfer(1'b0, 8'h8d + 8'(i), 8'h00, r);
      chk(16'(r), {7'h00, 1'b1, keep_tbl[i]});
    end
    chk(16'(cfg.channel_13), 16'h007f);
    chk(16'(cfg.calibration_value), 16'h007f);
    chk(16'(cfg.comm_slot), 16'h0007);
    chk(16'({cfg.time_code_scaling, cfg.output_power_level}), 16'h003f);
    chk(16'(cfg.time_code), 16'h00ff);
    chk(16'(cfg.no_wakeup_timeout), 16'h7fff);
    chk(16'(cfg.trial_max), 16'h00ff);
    chk(cfg.poll_max_ms, 16'h07d0);
    chk(16'({cfg.crc_reverse, cfg.rx_on_time, cfg.duty_cycle, cfg.role_master}), 16'h003f);
    chk(16'({cfg.xtal_slow_start, cfg.sync_lost_max}), 16'h007f);
    u_lmsb_host.xfer(1'b1, 8'h99, 8'h00, r);
    u_lmsb_host.xfer(1'b0, 8'h8d, 8'h00, r);
    chk(16'(r), 16'h017f);
  endtask : unused_bits
  task mid_reset;
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk(16'({rvalid, rdata}), 16'h0000);
    chk(16'(cfg.channel_13), 16'h002c);
    chk(16'(cfg.no_wakeup_timeout), 16'h000a);
    chk(cfg.poll_max_ms, 16'h00fa);
    chk(16'({cfg.crc_reverse, cfg.rx_on_time, cfg.duty_cycle, cfg.role_master}), 16'h001e);
    chk(16'({cfg.xtal_slow_start, cfg.sync_lost_max}), 16'h004f);
    reset_values();
  endtask : mid_reset
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    reset_values();
    channel_slots();
    settings_fields();
    unused_bits();
    mid_reset();
    summarize();
  end
endmodule : lmsb_bank_tb
